// File: src/prx_consts.svh
// constants for the receive and power interrupt status block
// assumes 16-bit register addresses and 8-bit register data
`ifndef PRX_CONSTS_SVH
`define PRX_CONSTS_SVH
`define PRX_AW 16
`define PRX_DW 8
`define PRX_ADDR_EVT 16'h1A82
`define PRX_ADDR_ERR 16'h1A83
`define PRX_ADDR_PWR 16'h1A84
`define PRX_ADDR_EVT_EN 16'h1A87
`define PRX_ADDR_ERR_EN 16'h1A88
`define PRX_ADDR_PWR_EN 16'h1A89
`define PRX_ADDR_PKT 16'h1A8A
`define PRX_EVT_RST 8'h40
`define PRX_ZERO 8'h00
`define PRX_EVT_WMASK 8'h6F
`define PRX_ERR_WMASK 8'h8F
`define PRX_PWR_WMASK 8'h01
`define PRX_PWR_EN_WMASK 8'h0F
`define PRX_PKT_WMASK 8'h79
`define PRX_EVT_EN_WMASK 8'hEF
`define PRX_B_CSTOP 3
`define PRX_B_WUP 2
`define PRX_B_FIFO 7
`define PRX_B_IDLE 6
`define PRX_B_CABLE 5
`define PRX_B_HARD 3
`define PRX_B_EOP 2
`define PRX_B_SOP 1
`define PRX_B_DONE 0
`define PRX_B_DBG 7
`define PRX_B_BAD 3
`define PRX_B_OVR 2
`define PRX_B_PCOL 1
`define PRX_B_DROP 0
`define PRX_B_WAKE 0
`define PRX_P_CRC 0
`define PRX_P_OVSZ 3
`define PRX_P_FULL 4
`define PRX_P_SYM 5
`define PRX_P_ODD 6
`endif

// File: src/prx_pkg.sv
// types shared by the receive interrupt status block
// assumes the datapath presents one-cycle event strobes
package prx_pkg;
  typedef struct packed {
    logic cable_rst;
    logic hard_rst;
    logic [4:0] sop_onehot;
    logic sop_valid;
    logic eop_valid;
    logic eop_bad;
    logic abort;
  } prx_frame_type;
  typedef struct packed {
    logic msg_ok;
    logic is_goodcrc;
    logic is_ping;
    logic duplicate;
  } prx_msg_type;
  typedef struct packed {
    logic bad_crc;
    logic sym_err;
    logic oversize;
    logic odd_nibble;
    logic no_space;
  } prx_fault_type;
  typedef enum logic [1:0] {PRX_IDLE, PRX_REPLY} prx_reply_type;
endpackage

// File: src/prx_irq_status.sv
// receive event, receive error and power wake status registers with enables
// assumes datapath strobes are synchronous to i_ref_clk; i_rx_activity is raw
//
// Overview of operation
// - status bits set by hardware, cleared only by writing one, except event bit 7
// - status records events whatever the enable, except wake bit 0; enable gates the interrupt
// - event bit 7 mirrors receive fifo not empty, read only
// - idle bit resets to one; sets on enable when idle, else on going idle
// - idle detection is clocked, so nothing happens with clocks stopped
// - event bit 5 sets on cable reset; bit 4 reserved reads zero
// - event bit 3 sets on hard reset from the partner
// - bit 2 sets on valid frame end of enabled start type; bad end drops
// - bit 1 sets on valid frame start of an enabled start type
// - bit 0 sets on good message, not on dropped goodcrc or duplicates
// - auto response: done bit sets before the goodcrc reply request
// - error bit 7 sets when a debug counter reaches its limit
// - debug bit is level driven and sets again while the limit holds
// - error bit 3 sets on corrupt packet, with packet status cause bit
// - error bit 2 sets on overrun; packet status bit 4 set, packet dropped
// - auto retry: unexpected message sets bit 1, is queued, sets done
// - such protocol error aborts the retry and flags transmit aborted
// - error bit 0 sets when a goodcrc or duplicate message is discarded
// - wake bit 0 set asynchronously by receive activity; 7:1 reserved
// - wake enable cleared prevents the wake bit from setting
// - wake bit ignores clock stop and wakeup enable settings
// - all enable bits clear after reset
`timescale 1ns/1ns
`include "prx_consts.svh"
module prx_irq_status (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [`PRX_AW-1:0] i_addr,
  input wire logic [`PRX_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`PRX_DW-1:0] o_rdata,
  input wire logic i_fifo_not_empty,
  input wire logic i_line_idle,
  input wire logic [4:0] i_sop_type_ctl,
  input wire prx_pkg::prx_frame_type i_frame,
  input wire prx_pkg::prx_msg_type i_msg,
  input wire prx_pkg::prx_fault_type i_fault,
  input wire logic i_auto_retry_mode,
  input wire logic i_auto_resp_mode,
  input wire logic i_goodcrc_expected,
  input wire logic i_crc_count_limit,
  input wire logic i_dup_count_limit,
  input wire logic i_rx_activity,
  output logic o_irq,
  output logic o_packet_drop,
  output logic o_queue_push,
  output logic o_reply_req,
  output logic o_retry_abort,
  output logic o_tx_aborted_set,
  output logic o_clock_stop_enable,
  output logic o_wakeup_enable
);
  logic [7:0] evt_r, evt_nxt, err_r, err_nxt, pkt_r, pkt_nxt;
  logic [7:0] evt_en_r, err_en_r, pwr_en_r;
  logic [7:0] evt_set, err_set, pkt_set, wmask;
  logic wr_evt, wr_err, wr_pwr, wr_pkt;
  logic idle_q_r, idle_en_q_r;
  logic frame_ok_r;
  logic sop_ok, eop_ok;
  logic drop_gcrc, drop_dup, pcol, done_set, corrupt;
  logic wake_seen_r, wake_s1_r, wake_s2_r, wake_clr_r;
  logic wake_rstn;
  logic [7:0] pwr_view;
  prx_pkg::prx_reply_type reply_st;

  assign wr_evt = i_wr && (i_addr == `PRX_ADDR_EVT);
  assign wr_err = i_wr && (i_addr == `PRX_ADDR_ERR);
  assign wr_pwr = i_wr && (i_addr == `PRX_ADDR_PWR);
  assign wr_pkt = i_wr && (i_addr == `PRX_ADDR_PKT);
  assign wmask = i_wdata;

  // frame start qualification against the start type control
  assign sop_ok = i_frame.sop_valid && ((i_frame.sop_onehot & i_sop_type_ctl) != 5'h00);
  assign eop_ok = i_frame.eop_valid && frame_ok_r;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      frame_ok_r <= 1'b0;
    end else if (sop_ok) begin
      frame_ok_r <= 1'b1;
    end else if (i_frame.sop_valid || i_frame.eop_valid || i_frame.eop_bad || i_frame.abort) begin
      frame_ok_r <= 1'b0;
    end
  end

  // message classification
  assign drop_gcrc = i_msg.msg_ok && i_auto_retry_mode && i_msg.is_goodcrc;
  assign drop_dup = i_msg.msg_ok && i_auto_resp_mode && i_msg.duplicate;
  assign pcol = i_msg.msg_ok && i_auto_retry_mode && i_goodcrc_expected
    && !i_msg.is_goodcrc && !i_msg.is_ping;
  assign done_set = i_msg.msg_ok && !drop_gcrc && !drop_dup;
  assign corrupt = i_fault.bad_crc || i_fault.sym_err || i_fault.oversize || i_fault.odd_nibble;

  // idle edge and enable edge trackers, clocked only
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      // line taken as quiet at reset, so no false going-idle edge follows reset
      idle_q_r <= 1'b1;
      idle_en_q_r <= 1'b0;
    end else begin
      idle_q_r <= i_line_idle;
      idle_en_q_r <= evt_en_r[`PRX_B_IDLE];
    end
  end

  always_comb begin
    evt_set = `PRX_ZERO;
    evt_set[`PRX_B_IDLE] = i_line_idle && ((!idle_q_r) ||
      (evt_en_r[`PRX_B_IDLE] && !idle_en_q_r));
    evt_set[`PRX_B_CABLE] = i_frame.cable_rst;
    evt_set[`PRX_B_HARD] = i_frame.hard_rst;
    evt_set[`PRX_B_EOP] = eop_ok;
    evt_set[`PRX_B_SOP] = sop_ok;
    evt_set[`PRX_B_DONE] = done_set;
  end

  always_comb begin
    err_set = `PRX_ZERO;
    err_set[`PRX_B_DBG] = i_crc_count_limit || i_dup_count_limit;
    err_set[`PRX_B_BAD] = corrupt;
    err_set[`PRX_B_OVR] = i_fault.no_space;
    err_set[`PRX_B_PCOL] = pcol;
    err_set[`PRX_B_DROP] = drop_gcrc || drop_dup;
  end

  always_comb begin
    pkt_set = `PRX_ZERO;
    pkt_set[`PRX_P_CRC] = i_fault.bad_crc;
    pkt_set[`PRX_P_OVSZ] = i_fault.oversize;
    pkt_set[`PRX_P_SYM] = i_fault.sym_err;
    pkt_set[`PRX_P_ODD] = i_fault.odd_nibble;
    pkt_set[`PRX_P_FULL] = i_fault.no_space;
  end

  // write-one-to-clear, a set in the same cycle wins
  always_comb begin
    evt_nxt = ((evt_r & ~(wr_evt ? wmask : `PRX_ZERO)) | evt_set) & `PRX_EVT_WMASK;
    evt_nxt[`PRX_B_FIFO] = i_fifo_not_empty;
    err_nxt = ((err_r & ~(wr_err ? wmask : `PRX_ZERO)) | err_set) & `PRX_ERR_WMASK;
    pkt_nxt = ((pkt_r & ~(wr_pkt ? wmask : `PRX_ZERO)) | pkt_set) & `PRX_PKT_WMASK;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      evt_r <= `PRX_EVT_RST;
      err_r <= `PRX_ZERO;
      pkt_r <= `PRX_ZERO;
    end else begin
      evt_r <= evt_nxt;
      err_r <= err_nxt;
      pkt_r <= pkt_nxt;
    end
  end

  // enable registers
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      evt_en_r <= `PRX_ZERO;
      err_en_r <= `PRX_ZERO;
      pwr_en_r <= `PRX_ZERO;
    end else if (i_wr) begin
      if (i_addr == `PRX_ADDR_EVT_EN) begin
        evt_en_r <= i_wdata & `PRX_EVT_EN_WMASK;
      end
      if (i_addr == `PRX_ADDR_ERR_EN) begin
        err_en_r <= i_wdata & `PRX_ERR_WMASK;
      end
      if (i_addr == `PRX_ADDR_PWR_EN) begin
        pwr_en_r <= i_wdata & `PRX_PWR_EN_WMASK;
      end
    end
  end

  // wake flag: captured on the activity edge with no system clock
  assign wake_rstn = i_resetn && !wake_clr_r;

  always_ff @(posedge i_rx_activity or negedge wake_rstn) begin
    if (!wake_rstn) begin
      wake_seen_r <= 1'b0;
    end else if (pwr_en_r[`PRX_B_WAKE]) begin
      wake_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
      wake_clr_r <= 1'b0;
    end else begin
      wake_s1_r <= wake_seen_r;
      wake_s2_r <= wake_s1_r;
      wake_clr_r <= wr_pwr && i_wdata[`PRX_B_WAKE];
    end
  end

  always_comb begin
    pwr_view = `PRX_ZERO;
    pwr_view[`PRX_B_WAKE] = wake_s2_r;
  end

  // interrupt output
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= ((evt_r & evt_en_r) != `PRX_ZERO) || ((err_r & err_en_r) != `PRX_ZERO)
        || ((pwr_view & pwr_en_r & `PRX_PWR_WMASK) != `PRX_ZERO);
    end
  end

  // datapath side effects
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_packet_drop <= 1'b0;
      o_queue_push <= 1'b0;
      o_retry_abort <= 1'b0;
      o_tx_aborted_set <= 1'b0;
    end else begin
      o_packet_drop <= i_frame.eop_bad || i_frame.abort || i_fault.no_space
        || drop_gcrc || drop_dup;
      o_queue_push <= done_set;
      o_retry_abort <= pcol;
      o_tx_aborted_set <= pcol;
    end
  end

  // goodcrc reply is requested only after the done bit is visible
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      reply_st <= prx_pkg::PRX_IDLE;
      o_reply_req <= 1'b0;
    end else begin
      case (reply_st)
        prx_pkg::PRX_IDLE: begin
          o_reply_req <= 1'b0;
          if (done_set && i_auto_resp_mode) begin
            reply_st <= prx_pkg::PRX_REPLY;
          end
        end
        prx_pkg::PRX_REPLY: begin
          o_reply_req <= 1'b1;
          reply_st <= prx_pkg::PRX_IDLE;
        end
        default: begin
          reply_st <= prx_pkg::PRX_IDLE;
          o_reply_req <= 1'b0;
        end
      endcase
    end
  end

  // control bits passed on to the clock manager
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_clock_stop_enable <= 1'b0;
      o_wakeup_enable <= 1'b0;
    end else begin
      o_clock_stop_enable <= pwr_en_r[`PRX_B_CSTOP];
      o_wakeup_enable <= pwr_en_r[`PRX_B_WUP];
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= `PRX_ZERO;
    end else if (i_rd) begin
      case (i_addr)
        `PRX_ADDR_EVT: o_rdata <= evt_r;
        `PRX_ADDR_ERR: o_rdata <= err_r;
        `PRX_ADDR_PWR: o_rdata <= pwr_view;
        `PRX_ADDR_EVT_EN: o_rdata <= evt_en_r;
        `PRX_ADDR_ERR_EN: o_rdata <= err_en_r;
        `PRX_ADDR_PWR_EN: o_rdata <= pwr_en_r;
        `PRX_ADDR_PKT: o_rdata <= pkt_r;
        default: o_rdata <= `PRX_ZERO;
      endcase
    end else begin
      o_rdata <= `PRX_ZERO;
    end
  end

  a_w1c_zero_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (wr_err && i_wdata == 8'h00 && err_set == 8'h00) |=> (err_r == $past(err_r)))
    else $error("error status changed on zero write");
  a_irq_enabled_bit: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    ((evt_r & evt_en_r) != 8'h00) |=> o_irq)
    else $error("enabled event did not raise interrupt");
  a_irq_none_enabled: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (evt_en_r == 8'h00 && err_en_r == 8'h00 && pwr_en_r == 8'h00) |=> !o_irq)
    else $error("interrupt with all enables clear");
  a_fifo_mirror: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    i_fifo_not_empty |=> evt_r[7])
    else $error("fifo bit does not follow fifo level");
  a_idle_on_enable: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_line_idle && $rose(evt_en_r[6])) |=> evt_r[6])
    else $error("idle bit not set on enable while idle");
  a_hard_rst_set: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    i_frame.hard_rst |=> evt_r[3])
    else $error("hard reset not recorded");
  a_done_no_drop: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (drop_gcrc && !$past(evt_r[0]) && !evt_r[0]) |=> (!evt_r[0] && err_r[0]))
    else $error("dropped goodcrc set done or missed drop");
  a_reply_after_done: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (done_set && i_auto_resp_mode && reply_st == prx_pkg::PRX_IDLE) |=> evt_r[0] ##1 o_reply_req)
    else $error("reply not requested after done bit");
  a_dbg_level: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_crc_count_limit || i_dup_count_limit) |=> err_r[7])
    else $error("debug bit not held by counter limit");
  a_pcol_abort: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    pcol |=> (o_retry_abort && o_tx_aborted_set && err_r[1] && evt_r[0]))
    else $error("protocol error did not abort retry");
  a_overrun_flags: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    i_fault.no_space |=> (err_r[2] && pkt_r[4] && o_packet_drop))
    else $error("overrun flags missing");
  a_wake_gated: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (!pwr_en_r[`PRX_B_WAKE] && !wake_seen_r) |=> !wake_s1_r)
    else $error("wake flag set while its enable was clear");
  a_wake_clear: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    wake_clr_r |-> !wake_seen_r)
    else $error("wake flag not cleared by write one");
  a_fifo_clear: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    !i_fifo_not_empty |=> !evt_r[`PRX_B_FIFO])
    else $error("fifo bit stays set with fifo empty");
  a_cable_set: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    i_frame.cable_rst |=> evt_r[`PRX_B_CABLE])
    else $error("cable reset not recorded");
  a_sop_disabled: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_frame.sop_valid && ((i_frame.sop_onehot & i_sop_type_ctl) == 5'h00) && !evt_r[`PRX_B_SOP])
    |=> !evt_r[`PRX_B_SOP])
    else $error("frame start of disabled type recorded");
  a_eop_unqualified: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_frame.eop_valid && !frame_ok_r && !evt_r[`PRX_B_EOP]) |=> !evt_r[`PRX_B_EOP])
    else $error("frame end recorded without enabled start");
  a_done_set: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_msg.msg_ok && !i_auto_retry_mode && !i_auto_resp_mode) |=> evt_r[`PRX_B_DONE])
    else $error("good message not recorded");
  a_bad_crc_set: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    i_fault.bad_crc |=> (err_r[`PRX_B_BAD] && pkt_r[`PRX_P_CRC]))
    else $error("bad crc not recorded with its cause");
  a_drop_flag: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (drop_gcrc || drop_dup) |=> (err_r[`PRX_B_DROP] && o_packet_drop))
    else $error("discarded packet not flagged");
endmodule

// File: tb/prx_partner_model.sv
// port partner on the cc line: frame, message and fault strobes and raw activity
// assumes the bench calls its tasks from one sequence, clocked by i_ref_clk
`timescale 1ns/1ns
module prx_partner_model (
  input wire logic i_ref_clk,
  output prx_pkg::prx_frame_type o_frame,
  output prx_pkg::prx_msg_type o_msg,
  output prx_pkg::prx_fault_type o_fault,
  output logic o_rx_activity
);
  initial begin
    o_frame = '0;
    o_msg = '0;
    o_fault = '0;
    o_rx_activity = 1'b0;
  end
  // one-cycle strobe set, quiet again at the next edge
  task automatic send(input logic [10:0] f, input logic [3:0] m, input logic [4:0] x);
    @(posedge i_ref_clk);
    o_frame <= f;
    o_msg <= m;
    o_fault <= x;
    @(posedge i_ref_clk);
    o_frame <= '0;
    o_msg <= '0;
    o_fault <= '0;
  endtask
  // start of bus activity raises the raw receive input
  task automatic burst();
    @(posedge i_ref_clk);
    o_rx_activity <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    o_rx_activity <= 1'b0;
  endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench for the receive and power interrupt status block
// assumes the partner model drives the datapath strobes and raw activity
`timescale 1ns/1ns
`include "prx_consts.svh"
module tb_top;
  typedef struct packed {
    logic [10:0] f;
    logic [3:0] m;
    logic [4:0] x;
    logic [15:0] a;
    logic [7:0] e;
  } prx_row_type;
  logic i_ref_clk, i_resetn, i_wr, i_rd, i_fifo_not_empty, i_line_idle;
  logic i_auto_retry_mode, i_auto_resp_mode, i_goodcrc_expected, i_crc_count_limit, i_dup_count_limit;
  logic o_irq, o_packet_drop, o_queue_push, o_reply_req, o_retry_abort, o_tx_aborted_set;
  logic o_clock_stop_enable, o_wakeup_enable, act_w;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  logic [4:0] i_sop_type_ctl;
  prx_pkg::prx_frame_type frame_w;
  prx_pkg::prx_msg_type msg_w;
  prx_pkg::prx_fault_type fault_w;
  int n_errors = 0;
  int checks = 0;
  prx_row_type rows [11] = '{
    '{11'h400, 4'h0, 5'h00, `PRX_ADDR_EVT, 8'h20},
    '{11'h200, 4'h0, 5'h00, `PRX_ADDR_EVT, 8'h08},
    '{11'h018, 4'h0, 5'h00, `PRX_ADDR_EVT, 8'h02},
    '{11'h004, 4'h0, 5'h00, `PRX_ADDR_EVT, 8'h04},
    '{11'h002, 4'h0, 5'h00, `PRX_ADDR_EVT, 8'h00},
    '{11'h000, 4'h8, 5'h00, `PRX_ADDR_EVT, 8'h01},
    '{11'h000, 4'h0, 5'h10, `PRX_ADDR_ERR, 8'h08},
    '{11'h000, 4'h0, 5'h08, `PRX_ADDR_ERR, 8'h08},
    '{11'h000, 4'h0, 5'h04, `PRX_ADDR_ERR, 8'h08},
    '{11'h000, 4'h0, 5'h02, `PRX_ADDR_ERR, 8'h08},
    '{11'h000, 4'h0, 5'h01, `PRX_ADDR_ERR, 8'h04}};

  prx_irq_status DUT (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_fifo_not_empty(i_fifo_not_empty),
    .i_line_idle(i_line_idle), .i_sop_type_ctl(i_sop_type_ctl), .i_frame(frame_w), .i_msg(msg_w),
    .i_fault(fault_w), .i_auto_retry_mode(i_auto_retry_mode), .i_auto_resp_mode(i_auto_resp_mode),
    .i_goodcrc_expected(i_goodcrc_expected), .i_crc_count_limit(i_crc_count_limit),
    .i_dup_count_limit(i_dup_count_limit), .i_rx_activity(act_w), .o_irq(o_irq),
    .o_packet_drop(o_packet_drop), .o_queue_push(o_queue_push), .o_reply_req(o_reply_req),
    .o_retry_abort(o_retry_abort), .o_tx_aborted_set(o_tx_aborted_set),
    .o_clock_stop_enable(o_clock_stop_enable), .o_wakeup_enable(o_wakeup_enable));
  prx_partner_model u_partner (.i_ref_clk(i_ref_clk), .o_frame(frame_w), .o_msg(msg_w),
    .o_fault(fault_w), .o_rx_activity(act_w));

  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  task automatic end_of_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  // read data is looked at in the single cycle after the strobe
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask
  task automatic flag(input logic s, input logic e);
    chk({7'h00, s}, {7'h00, e});
  endtask
  initial begin
    #40000;
    n_errors++;
    end_of_test();
  end

  initial begin
    {i_resetn, i_wr, i_rd, i_fifo_not_empty, i_auto_retry_mode, i_auto_resp_mode} = '0;
    {i_goodcrc_expected, i_crc_count_limit, i_dup_count_limit} = '0;
    i_addr = '0;
    i_wdata = '0;
    i_line_idle = 1'b1;
    i_sop_type_ctl = 5'h1F;
    repeat (5) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    rdchk(`PRX_ADDR_EVT, 8'h40);
    rdchk(`PRX_ADDR_ERR, 8'h00);
    rdchk(`PRX_ADDR_PWR, 8'h00);
    rdchk(`PRX_ADDR_EVT_EN, 8'h00);
    rdchk(`PRX_ADDR_ERR_EN, 8'h00);
    rdchk(`PRX_ADDR_PWR_EN, 8'h00);
    wr(`PRX_ADDR_EVT, 8'h00);
    rdchk(`PRX_ADDR_EVT, 8'h40);
    wr(`PRX_ADDR_EVT, 8'h40);
    rdchk(`PRX_ADDR_EVT, 8'h00);
    foreach (rows[i]) begin
      u_partner.send(rows[i].f, rows[i].m, rows[i].x);
      rdchk(rows[i].a, rows[i].e);
      wr(rows[i].a, rows[i].e);
      rdchk(rows[i].a, 8'h00);
    end
    rdchk(`PRX_ADDR_PKT, 8'h79);
    wr(`PRX_ADDR_PKT, 8'h79);
    rdchk(`PRX_ADDR_PKT, 8'h00);
    // frame start of a disabled type counts neither start nor end
    i_sop_type_ctl <= 5'h1E;
    u_partner.send(11'h018, 4'h0, 5'h00);
    u_partner.send(11'h004, 4'h0, 5'h00);
    rdchk(`PRX_ADDR_EVT, 8'h00);
    i_sop_type_ctl <= 5'h1F;
    i_fifo_not_empty <= 1'b1;
    rdchk(`PRX_ADDR_EVT, 8'h80);
    wr(`PRX_ADDR_EVT, 8'hFF);
    rdchk(`PRX_ADDR_EVT, 8'h80);
    i_fifo_not_empty <= 1'b0;
    rdchk(`PRX_ADDR_EVT, 8'h00);
    u_partner.send(11'h400, 4'h0, 5'h00);
    repeat (2) @(posedge i_ref_clk);
    #1 flag(o_irq, 1'b0);
    wr(`PRX_ADDR_EVT_EN, 8'h20);
    repeat (2) @(posedge i_ref_clk);
    #1 flag(o_irq, 1'b1);
    wr(`PRX_ADDR_EVT, 8'h20);
    repeat (2) @(posedge i_ref_clk);
    #1 flag(o_irq, 1'b0);
    wr(`PRX_ADDR_EVT_EN, 8'h40);
    rdchk(`PRX_ADDR_EVT, 8'h40);
    wr(`PRX_ADDR_EVT, 8'h40);
    i_line_idle <= 1'b0;
    rdchk(`PRX_ADDR_EVT, 8'h00);
    i_line_idle <= 1'b1;
    rdchk(`PRX_ADDR_EVT, 8'h40);
    wr(`PRX_ADDR_EVT, 8'h40);
    wr(`PRX_ADDR_EVT_EN, 8'h00);
    i_auto_retry_mode <= 1'b1;
    u_partner.send(11'h000, 4'hC, 5'h00);
    #1 flag(o_packet_drop, 1'b1);
    rdchk(`PRX_ADDR_EVT, 8'h00);
    rdchk(`PRX_ADDR_ERR, 8'h01);
    wr(`PRX_ADDR_ERR, 8'h01);
    i_goodcrc_expected <= 1'b1;
    u_partner.send(11'h000, 4'h8, 5'h00);
    #1 flag(o_tx_aborted_set, 1'b1);
    flag(o_retry_abort, 1'b1);
    flag(o_queue_push, 1'b1);
    flag(o_packet_drop, 1'b0);
    rdchk(`PRX_ADDR_ERR, 8'h02);
    rdchk(`PRX_ADDR_EVT, 8'h01);
    wr(`PRX_ADDR_ERR, 8'h02);
    wr(`PRX_ADDR_EVT, 8'h01);
    // a ping while a goodcrc is expected is no protocol error
    u_partner.send(11'h000, 4'hA, 5'h00);
    rdchk(`PRX_ADDR_ERR, 8'h00);
    rdchk(`PRX_ADDR_EVT, 8'h01);
    wr(`PRX_ADDR_EVT, 8'h01);
    {i_auto_retry_mode, i_goodcrc_expected, i_auto_resp_mode} <= 3'b001;
    u_partner.send(11'h000, 4'h9, 5'h00);
    rdchk(`PRX_ADDR_EVT, 8'h00);
    rdchk(`PRX_ADDR_ERR, 8'h01);
    wr(`PRX_ADDR_ERR, 8'h01);
    u_partner.send(11'h000, 4'h8, 5'h00);
    #1 flag(o_reply_req, 1'b0);
    @(posedge i_ref_clk);
    #1 flag(o_reply_req, 1'b1);
    rdchk(`PRX_ADDR_EVT, 8'h01);
    wr(`PRX_ADDR_EVT, 8'h01);
    i_auto_resp_mode <= 1'b0;
    i_crc_count_limit <= 1'b1;
    rdchk(`PRX_ADDR_ERR, 8'h80);
    wr(`PRX_ADDR_ERR, 8'h80);
    rdchk(`PRX_ADDR_ERR, 8'h80);
    {i_crc_count_limit, i_dup_count_limit} <= 2'b01;
    wr(`PRX_ADDR_ERR, 8'h80);
    rdchk(`PRX_ADDR_ERR, 8'h80);
    i_dup_count_limit <= 1'b0;
    wr(`PRX_ADDR_ERR, 8'h80);
    rdchk(`PRX_ADDR_ERR, 8'h00);
    u_partner.burst();
    repeat (4) @(posedge i_ref_clk);
    rdchk(`PRX_ADDR_PWR, 8'h00);
    wr(`PRX_ADDR_PWR_EN, 8'h0D);
    @(posedge i_ref_clk);
    #1 flag(o_clock_stop_enable, 1'b1);
    flag(o_wakeup_enable, 1'b1);
    u_partner.burst();
    repeat (4) @(posedge i_ref_clk);
    rdchk(`PRX_ADDR_PWR, 8'h01);
    flag(o_irq, 1'b1);
    wr(`PRX_ADDR_PWR, 8'h01);
    repeat (3) @(posedge i_ref_clk);
    rdchk(`PRX_ADDR_PWR, 8'h00);
    wr(`PRX_ADDR_PWR_EN, 8'h01);
    u_partner.burst();
    repeat (4) @(posedge i_ref_clk);
    rdchk(`PRX_ADDR_PWR, 8'h01);
    flag(o_clock_stop_enable, 1'b0);
    wr(`PRX_ADDR_PWR, 8'h01);
    wr(`PRX_ADDR_PWR_EN, 8'h00);
    rdchk(16'h1A90, 8'h00);
    u_partner.send(11'h400, 4'h0, 5'h00);
    i_resetn <= 1'b0;
    @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    rdchk(`PRX_ADDR_EVT, 8'h40);
    end_of_test();
  end
endmodule
